// [verilog/cssc_defs.svh]
// Purpose: Constants for the converter serial command master
// Assumes: 10 MHz system clock
// Notes: Offsets are byte addresses on the control bus
`ifndef CSSC_DEFS_SVH
`define CSSC_DEFS_SVH
// Control register offsets
`define CSSC_OFF_CTRL 8'h00
`define CSSC_OFF_CMD 8'h04
`define CSSC_OFF_TXD 8'h08
`define CSSC_OFF_STAT 8'h0c
`define CSSC_OFF_RXD 8'h10
// Control register field positions
`define CSSC_CTRL_ENA 0
`define CSSC_CTRL_AUTOCFG 1
`define CSSC_CMD_GO 31
// Reset values
`define CSSC_CTRL_RST 32'h0000_0000
// Timing figures in their own units
`define CSSC_CLK_NS 100
`define CSSC_HALF_NS 500
`define CSSC_RST_WAIT_US 200
`define CSSC_CFG_WAIT_US 1000
`define CSSC_RAMW_WAIT_US 10
`define CSSC_CMP_WAIT_US 1000
`define CSSC_PROG_WAIT_US 4000
// Cycle counts derived from the figures, least times rounded up
`define CSSC_HALF_CYC ((`CSSC_HALF_NS + `CSSC_CLK_NS - 1) / `CSSC_CLK_NS)
`define CSSC_US_CYC(t) (((t) * 1000 + `CSSC_CLK_NS - 1) / `CSSC_CLK_NS)
// Opcodes
`define CSSC_OP_RAMW 8'h00
`define CSSC_OP_RAMR 8'h40
`define CSSC_OP_PWRRST 8'hf0
`define CSSC_OP_INITRST 8'hc0
`define CSSC_OP_CONT 8'hcc
`define CSSC_OP_SINGLE 8'hce
`define CSSC_OP_WDOFF 8'h9e
`define CSSC_OP_BGAPON 8'h87
`define CSSC_OP_ENAON 8'h91
`define CSSC_OP_CMPRD 8'ha0
`define CSSC_OP_NVWR 8'ha1
`define CSSC_OP_NVER 8'ha4
`define CSSC_OP_USRRD 8'ha5
`endif

// [verilog/cssc_pkg.sv]
// Purpose: Types for the converter serial command master
// Assumes: Constants live in cssc_defs.svh
// Notes: States are Gray coded along the usual path except the step from wait back to idle
package cssc_pkg;
    typedef enum logic [2:0] {
        CSSC_IDLE = 3'h0,
        CSSC_PULSE = 3'h1,
        CSSC_SHIFT = 3'h3,
        CSSC_NEXT = 3'h2,
        CSSC_WAIT = 3'h6
    } cssc_state_e;
    typedef logic [31:0] cssc_word_t;
endpackage : cssc_pkg

// [verilog/cssc_sync.sv]
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Single system clock
// Notes: The first stage feeds only the second
`timescale 1ns/1ps
module cssc_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Data
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    // Two stages to settle metastability
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule : cssc_sync

// [verilog/cssc_axil.sv]
// Purpose: AXI4-Lite slave for the command master registers
// Assumes: One outstanding write and read, 32-bit words
// Notes: Unmapped reads return zero with OKAY, writes to them are dropped
`timescale 1ns/1ps
`include "cssc_defs.svh"
module cssc_axil (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // Write address and data
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // Read
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Register side
    output logic o_wr,
    output logic [7:0] o_wa,
    output logic [31:0] o_wd,
    output logic [7:0] o_ra,
    input wire logic [31:0] i_rd
);
    logic aw_q;
    logic w_q;
    logic [7:0] awa_q;
    logic [31:0] wd_q;

    assign o_awready = !aw_q && !o_bvalid;
    assign o_wready = !w_q && !o_bvalid;
    assign o_bresp = 2'h0;
    assign o_rresp = 2'h0;
    assign o_arready = !o_rvalid;
    assign o_ra = i_araddr;
    assign o_wr = aw_q && w_q;
    assign o_wa = awa_q;
    assign o_wd = wd_q;

    // Collect address and data in either order, answer once both are in
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            o_bvalid <= 1'b0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_q <= 1'b1;
                awa_q <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_q <= 1'b1;
                wd_q <= i_wdata;
            end
            if (aw_q && w_q) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                o_bvalid <= 1'b1;
            end
            if (o_bvalid && i_bready)
                o_bvalid <= 1'b0;
        end
    end

    // Read data is registered one cycle after the address
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
        end else if (i_arvalid && o_arready) begin
            o_rvalid <= 1'b1;
            o_rdata <= i_rd;
        end else if (i_rready) begin
            o_rvalid <= 1'b0;
        end
    end
endmodule : cssc_axil

// [verilog/cssc_master.sv]
// Purpose: Serial master that drives a strain-gauge converter command port
// Assumes: 10 MHz clock, software frames each command over AXI4-Lite
// Notes: Data pin is sampled, its edges and the serial clock are ours
`timescale 1ns/1ps
`include "cssc_defs.svh"
module cssc_master #(
    parameter int RST_WAIT = `CSSC_US_CYC(`CSSC_RST_WAIT_US),
    parameter int CFG_WAIT = `CSSC_US_CYC(`CSSC_CFG_WAIT_US),
    parameter int RAMW_WAIT = `CSSC_US_CYC(`CSSC_RAMW_WAIT_US),
    parameter int CMP_WAIT = `CSSC_US_CYC(`CSSC_CMP_WAIT_US),
    parameter int PROG_WAIT = `CSSC_US_CYC(`CSSC_PROG_WAIT_US)
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_nrst,
    // AXI4-Lite write
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output cssc_pkg::cssc_word_t o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Device pins
    output logic o_serial_port_select,
    output logic o_chip_select_low,
    output logic o_sck,
    output logic o_sdi,
    input wire logic i_sdo
);
    import cssc_pkg::*;

    localparam int CW = 16;
    localparam logic [CW-1:0] HALF = CW'(`CSSC_HALF_CYC);

    cssc_state_e state_q;
    logic [31:0] ctrl_q;
    logic [63:0] txd_q;
    logic [3:0] nbytes_q;
    logic [3:0] byte_q;
    logic [2:0] bit_q;
    logic [7:0] op_q;
    logic [7:0] sh_q;
    logic [CW-1:0] half_q;
    logic [23:0] wait_q;
    logic [31:0] rxd_q;
    logic sck_q;
    logic busy;
    logic go;
    logic wr;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] rd;
    logic sdo_s;
    logic sdo_prev_q;
    logic ready_q;
    logic ena;

    cssc_axil u_bus (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_awaddr(i_awaddr),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .o_bresp(o_bresp),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .i_araddr(i_araddr),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .o_wr(wr),
        .o_wa(wa),
        .o_wd(wd),
        .o_ra(ra),
        .i_rd(rd)
    );

    // Data out comes from the device, so it crosses two flops first
    cssc_sync #(.W(1)) u_sync (
        .i_mclk(i_mclk),
        .i_nrst(i_nrst),
        .i_d(i_sdo),
        .o_q(sdo_s)
    );

    // One opcode per frame, so software keeps the command order
    assign busy = (state_q != CSSC_IDLE);
    assign ena = ctrl_q[`CSSC_CTRL_ENA];
    assign go = wr && (wa == `CSSC_OFF_CMD) && wd[`CSSC_CMD_GO] && !busy;
    assign o_serial_port_select = ena;
    assign o_sck = sck_q;
    assign o_sdi = sh_q[7];

    // Register writes; frames are refused while one is running
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            ctrl_q <= `CSSC_CTRL_RST;
            txd_q <= 64'h0;
            nbytes_q <= 4'h0;
        end else if (wr) begin
            if (wa == `CSSC_OFF_CTRL)
                ctrl_q <= wd;
            if (wa == `CSSC_OFF_TXD && !busy)
                txd_q <= {txd_q[31:0], wd};
            // The buffer holds eight bytes, so larger counts are cut to
            // eight; a compare read needs more and is not carried whole
            if (go)
                nbytes_q <= (wd[3:0] > 4'h8) ? 4'h8 : wd[3:0];
        end
    end

    // Read mux: status shows busy, data out level and a result flag
    always_comb begin
        case (ra)
            `CSSC_OFF_CTRL: rd = ctrl_q;
            `CSSC_OFF_STAT: rd = {29'h0, ready_q, sdo_s, busy};
            `CSSC_OFF_RXD: rd = rxd_q;
            default: rd = 32'h0;
        endcase
    end

    // A falling edge on data out while idle marks a new result
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            sdo_prev_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            sdo_prev_q <= sdo_s;
            if (!busy && sdo_prev_q && !sdo_s)
                ready_q <= 1'b1;
            else if (go)
                ready_q <= 1'b0;
        end
    end

    // Frame engine: select pulse, then bytes, then the post-frame wait
    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            state_q <= CSSC_IDLE;
            o_chip_select_low <= 1'b0;
            sck_q <= 1'b0;
            half_q <= '0;
            byte_q <= 4'h0;
            bit_q <= 3'h0;
            op_q <= 8'h00;
            sh_q <= 8'h00;
            wait_q <= 24'h0;
            rxd_q <= 32'h0;
        end else begin
            case (state_q)
                CSSC_IDLE: begin
                    if (go) begin
                        // Select goes high for one half period
                        o_chip_select_low <= 1'b1;
                        half_q <= HALF;
                        op_q <= txd_q[63:56];
                        byte_q <= 4'h0;
                        state_q <= CSSC_PULSE;
                    end
                end
                CSSC_PULSE: begin
                    if (half_q > 1) begin
                        half_q <= half_q - 1'b1;
                    end else if (o_chip_select_low) begin
                        o_chip_select_low <= 1'b0;
                        half_q <= HALF;
                    end else begin
                        // Setup time before first clock edge
                        sh_q <= txd_q[63:56];
                        bit_q <= 3'h0;
                        half_q <= HALF;
                        state_q <= CSSC_SHIFT;
                    end
                end
                CSSC_SHIFT: begin
                    if (half_q > 1) begin
                        half_q <= half_q - 1'b1;
                    end else begin
                        half_q <= HALF;
                        sck_q <= !sck_q;
                        if (!sck_q) begin
                            // Rising edge: device sample, take its bit
                            rxd_q <= {rxd_q[30:0], sdo_s};
                        end else if (bit_q == 3'h7) begin
                            state_q <= CSSC_NEXT;
                        end else begin
                            // Falling edge: next bit goes out
                            sh_q <= {sh_q[6:0], 1'b0};
                            bit_q <= bit_q + 1'b1;
                        end
                    end
                end
                CSSC_NEXT: begin
                    if (byte_q + 1'b1 < nbytes_q) begin
                        byte_q <= byte_q + 1'b1;
                        sh_q <= txd_q[8'(55 - 8 * byte_q) -: 8];
                        bit_q <= 3'h0;
                        state_q <= CSSC_SHIFT;
                    end else begin
                        state_q <= CSSC_WAIT;
                        // Hold-off chosen from the opcode just sent
                        case (op_q)
                            `CSSC_OP_PWRRST, `CSSC_OP_INITRST:
                                wait_q <= ctrl_q[`CSSC_CTRL_AUTOCFG]
                                    ? 24'(CFG_WAIT)
                                    : 24'(RST_WAIT);
                            `CSSC_OP_RAMW: wait_q <= 24'(RAMW_WAIT);
                            `CSSC_OP_CMPRD: wait_q <= 24'(CMP_WAIT);
                            `CSSC_OP_NVWR: wait_q <= 24'(PROG_WAIT);
                            default: wait_q <= 24'h1;
                        endcase
                    end
                end
                CSSC_WAIT: begin
                    if (wait_q > 1)
                        wait_q <= wait_q - 1'b1;
                    else
                        state_q <= CSSC_IDLE;
                end
                default: state_q <= CSSC_IDLE;
            endcase
        end
    end

    // Serial clock stays low whenever no byte is moving
    a_sck_idle_low: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        state_q != CSSC_SHIFT |-> ##0 !sck_q)
        else $error("serial clock not low outside shift");

    // Within a byte, data may change only right after a falling clock
    a_sdi_stable: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (state_q == CSSC_SHIFT && $past(state_q) == CSSC_SHIFT
            && $changed(o_sdi)) |-> $fell(sck_q))
        else $error("data moved off the falling edge");

    sequence s_pulse_hi;
        o_chip_select_low [*5];
    endsequence

    // Every frame opens with a full-width select pulse
    a_select_pulse: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        $rose(o_chip_select_low) |-> s_pulse_hi ##1 !o_chip_select_low)
        else $error("select pulse has wrong width");

    // The power-up reset opcode with autoload off is followed by the reset hold-off
    a_reset_wait: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (state_q == CSSC_NEXT && byte_q + 1'b1 >= nbytes_q
            && op_q == `CSSC_OP_PWRRST && !ctrl_q[`CSSC_CTRL_AUTOCFG])
        |=> wait_q == 24'(RST_WAIT))
        else $error("reset hold-off wrong");

    // With autoload on, both reset opcodes take the longer hold-off
    a_cfg_wait: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (state_q == CSSC_NEXT && byte_q + 1'b1 >= nbytes_q
            && (op_q == `CSSC_OP_PWRRST || op_q == `CSSC_OP_INITRST)
            && ctrl_q[`CSSC_CTRL_AUTOCFG])
        |=> wait_q == 24'(CFG_WAIT))
        else $error("autoload hold-off wrong");

    // A RAM write is followed by its pause
    a_ramw_wait: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (state_q == CSSC_NEXT && byte_q + 1'b1 >= nbytes_q
            && op_q == `CSSC_OP_RAMW)
        |=> wait_q == 24'(RAMW_WAIT))
        else $error("RAM write pause wrong");

    // A compare read leaves the device time to work out its answer
    a_cmp_wait: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (state_q == CSSC_NEXT && byte_q + 1'b1 >= nbytes_q
            && op_q == `CSSC_OP_CMPRD)
        |=> wait_q == 24'(CMP_WAIT))
        else $error("compare hold-off wrong");

    // A word write frame is followed by the programming time
    a_prog_wait: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (state_q == CSSC_NEXT && byte_q + 1'b1 >= nbytes_q
            && op_q == `CSSC_OP_NVWR)
        |=> wait_q == 24'(PROG_WAIT))
        else $error("programming hold-off wrong");

    // Port select follows the control bit
    a_port_sel: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        $past(wr && wa == `CSSC_OFF_CTRL) |-> o_serial_port_select
            == $past(wd[`CSSC_CTRL_ENA]))
        else $error("port select not following control");

    // Eight falling clocks make one byte
    a_byte_len: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        $rose(state_q == CSSC_NEXT) |-> $past(bit_q) == 3'h7)
        else $error("byte not eight bits");

    // A falling data line while idle raises the result flag
    a_result_flag: assert property (
        @(posedge i_mclk) disable iff (!i_nrst)
        (!busy && sdo_prev_q && !sdo_s && !go) |=> ready_q)
        else $error("result edge missed");
endmodule : cssc_master

// [test/cssc_dev_model.sv]
// Purpose: Behavioural converter command port facing the serial master
// Assumes: Each frame opens with a high select pulse; clock idles low
// Notes: Timing faults of the master are counted on o_errs, not printed
`timescale 1ns/1ps
module cssc_dev_model #(
    parameter int WAIT_NS = 2000,
    parameter int RAMW_NS = 2000,
    parameter logic [23:0] RESULT = 24'h3c_a55a,
    parameter int CONV_NS = 30000
) (
    // Device pins
    input wire logic i_sel,
    input wire logic i_cs,
    input wire logic i_sck,
    input wire logic i_sdi,
    output logic o_sdo,
    // Bench view
    output int o_errs
);
    logic [23:0] ram [0:127];
    logic [23:0] sh;
    logic [23:0] out;
    logic [7:0] op;
    logic [7:0] adr;
    int nbits;
    logic intm;
    realtime t_end;
    realtime need;

    // Power-up state of the model
    initial begin
        o_errs = 0;
        nbits = 0;
        intm = 1'b0;
        o_sdo = 1'b0;
        out = 24'h0;
        t_end = 0;
        need = 0;
    end

    // Conversion: line held high in signalling mode, falls on a result
    task automatic conv();
        intm = 1'b1;
        o_sdo = 1'b1;
        #(CONV_NS);
        ram[20] = RESULT;
        ram[0] = RESULT;
        if (intm) o_sdo = 1'b0;
    endtask : conv

    // Select pulse opens a frame and ends interrupt signalling
    always @(posedge i_cs) if (i_sel) begin
        if (i_sck !== 1'b0 || $realtime - t_end < need) o_errs++;
        nbits = 0;
        intm = 1'b0;
        need = 0;
    end

    // Bits taken on the rising clock, most significant first
    always @(posedge i_sck) if (i_sel && !i_cs) begin
        sh = {sh[22:0], i_sdi};
        nbits++;
        if (nbits == 8) begin
            op = sh[7:0];
            if (op == 8'hf0 || op == 8'hc0) need = WAIT_NS;
            if (op == 8'hcc || op == 8'hce) fork conv(); join_none
        end
        if (nbits == 16) adr = sh[7:0];
        if (nbits == 16 && op == 8'h40) out = ram[adr[6:0]];
        if (nbits == 24 && op == 8'ha5) out = {sh[15:0] ^ 16'hc3a5, 8'h0};
        if (nbits == 40 && op == 8'h00) begin
            ram[adr[6:0]] = sh;
            need = RAMW_NS;
        end
    end

    // Data leaves on the falling clock; spent bits come back inverted
    always @(negedge i_sck) begin
        t_end = $realtime;
        if (!intm) begin
            o_sdo = out[23];
            out = {out[22:0], ~out[23]};
        end
    end
endmodule : cssc_dev_model

// [test/cssc_master_tb_top.sv]
// Purpose: Self-checking bench for the converter serial command master
// Assumes: Device model on the pins, AXI4-Lite driven from tasks
// Notes: Long waits shortened through parameters to keep the run brief
`timescale 1ns/1ps
`include "cssc_defs.svh"
module cssc_master_tb_top;
    import cssc_pkg::*;
    localparam logic [23:0] RES = 24'h3c_a55a;
    logic i_mclk = 1'b0;
    logic i_nrst = 1'b0;
    logic [7:0] awaddr = 8'h0;
    logic [7:0] araddr = 8'h0;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic [3:0] wstrb = 4'hf;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp;
    cssc_word_t o_rdata;
    logic o_serial_port_select, o_chip_select_low, o_sck, o_sdi, sdo;
    int dev_errs;
    int err_total = 0;
    int check_count = 0;
    logic [23:0] ram_q [0:127];

    // Clock at 10 MHz
    always #50 i_mclk = ~i_mclk;

    cssc_master #(.RST_WAIT(20), .CFG_WAIT(40), .RAMW_WAIT(20),
        .CMP_WAIT(20), .PROG_WAIT(20)) u_cssc_master (
        .i_mclk(i_mclk), .i_nrst(i_nrst), .i_awaddr(awaddr),
        .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata),
        .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(o_wready),
        .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(bready),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready),
        .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
        .i_rready(rready), .o_serial_port_select(o_serial_port_select),
        .o_chip_select_low(o_chip_select_low), .o_sck(o_sck),
        .o_sdi(o_sdi), .i_sdo(sdo));

    // Model keeps its own timing defaults; its result equals RES
    cssc_dev_model u_cssc_dev_model (
        .i_sel(o_serial_port_select), .i_cs(o_chip_select_low),
        .i_sck(o_sck), .i_sdi(o_sdi), .o_sdo(sdo), .o_errs(dev_errs));

    task automatic chk(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test

    // Handshakes are judged mid-cycle, acted on at the next rising edge
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && dd)) begin
            @(negedge i_mclk);
            ad = ad | (awvalid & o_awready);
            dd = dd | (wvalid & o_wready);
            @(posedge i_mclk);
            if (ad) awvalid <= 1'b0;
            if (dd) wvalid <= 1'b0;
        end
        bready <= 1'b1;
        do begin
            @(negedge i_mclk);
            ad = o_bvalid;
            @(posedge i_mclk);
        end while (ad !== 1'b1);
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d);
        logic hs;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(negedge i_mclk);
            hs = o_arready;
            @(posedge i_mclk);
        end while (hs !== 1'b1);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do begin
            @(negedge i_mclk);
            hs = o_rvalid;
            d = o_rdata;
            @(posedge i_mclk);
        end while (hs !== 1'b1);
        rready <= 1'b0;
    endtask : axr

    // One frame of n bytes; t returns cycles from go to busy clear
    task automatic frame(input logic [63:0] v, input int n, output int t);
        logic [31:0] s;
        realtime t0;
        axw(`CSSC_OFF_TXD, v[63:32]);
        axw(`CSSC_OFF_TXD, v[31:0]);
        axw(`CSSC_OFF_CMD, 32'h8000_0000 + 32'(n));
        t0 = $realtime;
        s = 32'h1;
        while (s[0] !== 1'b0) axr(`CSSC_OFF_STAT, s);
        t = int'(($realtime - t0) / 100.0);
    endtask : frame

    // Watchdog, about six times the expected run
    initial begin
        #(60000 * 100);
        err_total++;
        finish_test();
    end

    initial begin
        logic [31:0] r;
        logic [7:0] a;
        logic [23:0] d;
        int t, w, n;
        logic [7:0] cv [2];
        logic [15:0] ua [2];
        logic [7:0] hop [6];
        cv = '{8'hcc, 8'hce};
        ua = '{16'd2000, 16'd2047};
        hop = '{8'hf0, 8'hc0, 8'hf0, 8'hc0, 8'ha0, 8'ha1};
        void'($urandom(33110));
        repeat (12) @(posedge i_mclk);
        i_nrst <= 1'b1;
        @(posedge i_mclk);
        chk("select after reset", 32'h0, {31'h0, o_serial_port_select});
        axr(`CSSC_OFF_CTRL, r);
        chk("control reset", `CSSC_CTRL_RST, r);
        axr(8'h3c, r);
        chk("unmapped read", 32'h0, r);
        axw(`CSSC_OFF_CTRL, 32'h1);
        chk("select on", 32'h1, {31'h0, o_serial_port_select});
        // Both reset opcodes, without and with autoload, then the
        // compare read and word write opcodes with their own hold-offs
        for (int k = 0; k < 6; k++) begin
            w = (k == 2 || k == 3) ? 40 : 20;
            axw(`CSSC_OFF_CTRL, 32'h1 | 32'((w > 20) ? 2 : 0));
            frame({hop[k], 56'h0}, 1, t);
            n = int'(t >= 85 + w && t <= 105 + w);
            chk("hold-off", 32'h1, 32'(n));
            frame({8'h9e, 56'h0}, 1, t);
        end
        axw(`CSSC_OFF_CTRL, 32'h1);
        // Word writes at the ends and inside the configuration range
        for (int k = 0; k < 6; k++) begin
            a = (k == 0) ? 8'd48 : (k == 1) ? 8'd66 : 8'(48 + $urandom_range(18));
            d = 24'($urandom);
            ram_q[a[6:0]] = d;
            frame({8'h00, a, d, 24'h0}, 5, t);
            frame({8'h40, a, 48'h0}, 5, t);
            axr(`CSSC_OFF_RXD, r);
            chk("ram word", {8'h0, ram_q[a[6:0]]}, {8'h0, r[23:0]});
        end
        // Continuous and single conversion, result signalled on the data line
        foreach (cv[i]) begin
            frame({cv[i], 56'h0}, 1, t);
            r = 32'h0;
            n = 0;
            while (r[2] !== 1'b1 && n < 500) begin
                axr(`CSSC_OFF_STAT, r);
                n++;
            end
            chk("result flag", 32'h4, r & 32'h4);
            frame({8'h40, 8'h00, 48'h0}, 5, t);
            axr(`CSSC_OFF_RXD, r);
            chk("copied result", {8'h0, RES}, {8'h0, r[23:0]});
        end
        // User area, both ends, after the enabling opcodes
        frame({8'h87, 56'h0}, 1, t);
        frame({8'h91, 56'h0}, 1, t);
        foreach (ua[i]) begin
            frame({8'ha5, ua[i], 40'h0}, 5, t);
            axr(`CSSC_OFF_RXD, r);
            chk("user word", {16'h0, ua[i] ^ 16'hc3a5}, {16'h0, r[15:0]});
        end
        chk("device timing faults", 32'h0, 32'(dev_errs));
        finish_test();
    end
endmodule : cssc_master_tb_top
